/* File: hdl/ecp_pkg.sv */
// shared constants and carrier types of the extended-capabilities parallel port
package ecp_pkg;
   localparam int PWORD_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int ENTRY_W = PWORD_W + 1;
   // register offsets from the port base
   localparam logic [10:0] OFS_DATA = 11'h000;
   localparam logic [10:0] OFS_DSR = 11'h001;
   localparam logic [10:0] OFS_DCR = 11'h002;
   localparam logic [10:0] OFS_FIFO = 11'h400;
   localparam logic [10:0] OFS_CFGB = 11'h401;
   localparam logic [10:0] OFS_ECR = 11'h402;
   // mode field encodings of the extended control register
   localparam logic [2:0] MODE_SPP = 3'h0;
   localparam logic [2:0] MODE_PS2 = 3'h1;
   localparam logic [2:0] MODE_COMPAT_BYTE_QUEUE = 3'h2;
   localparam logic [2:0] MODE_ECP = 3'h3;
   localparam logic [2:0] MODE_TEST = 3'h6;
   localparam logic [2:0] MODE_CNFG = 3'h7;
   // control register bit positions
   localparam int DCR_STROBE = 0;
   localparam int DCR_AUTOFD = 1;
   localparam int DCR_INIT = 2;
   localparam int DCR_SELIN = 3;
   localparam int DCR_ACKINT = 4;
   localparam int DCR_DIR = 5;
   // extended control register bit positions
   localparam int ECR_EMPTY = 0;
   localparam int ECR_FULL = 1;
   localparam int ECR_SERVICE = 2;
   localparam int ECR_DMA_TRANSFER_ENABLE = 3;
   localparam int ECR_ERRN = 4;
   localparam int ECR_MODE = 5;
   // reset values, fixed capability word and service threshold
   localparam logic [5:0] DCR_RESET = 6'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic ERRN_RESET = 1'b1;
   localparam logic DMA_TRANSFER_ENABLE_RESET = 1'b0;
   localparam logic SERVICE_RESET = 1'b0;
   localparam logic [7:0] CFGA_VALUE = 8'h10;
   localparam logic [4:0] SERVICE_THRESH = 5'h08;

   // pins the port drives toward the peripheral (pin levels)
   typedef struct packed {
      logic host_write_clock;
      logic host_flow_line;
      logic direction_select_out;
      logic printer_choose_out;
   } link_out_type;

   // pins the peripheral drives (pin levels)
   typedef struct packed {
      logic peripheral_read_clock;
      logic peripheral_handshake_in;
      logic peripheral_fault_request;
      logic direction_turn_grant;
      logic online_in;
   } link_in_type;

   // one register access from the host front end
   typedef struct packed {
      logic rd;
      logic wr;
      logic [10:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
endpackage : ecp_pkg

/* File: hdl/fifo_store.sv */
// shared byte storage for all port queues, registered read data
`timescale 1ns/100ps
module fifo_store #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   input wire logic re,
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   // no reset on the array; read data holds until the next read
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule : fifo_store

/* File: hdl/ecp_parallel_port.sv */
// extended-capabilities parallel port: registers, shared queue, link engine
`timescale 1ns/100ps
module ecp_parallel_port
   import ecp_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire reg_req_type reg_req,
   output logic [7:0] reg_rdata,
   output logic dma_req,
   input wire logic dma_ack,
   input wire logic [2:0] cfg_irq_sel,
   input wire logic [2:0] cfg_dma_sel,
   input wire link_in_type link_in,
   output link_out_type link_out,
   input wire logic [PWORD_W-1:0] pd_in,
   output logic [PWORD_W-1:0] pd_out,
   output logic pd_oe,
   output logic fault_irq,
   output logic fifo_service_request
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("DEPTH must be a power of two, at least 2");
      end
   end

   typedef enum logic [3:0] {
      ST_IDLE, ST_FETCH, ST_SETUP, ST_STROBE, ST_HOLD,
      ST_TURN_REV, ST_TURN_FWD, ST_REV_REQ, ST_REV_RELEASE, ST_REPEAT
   } link_state_type;

   function automatic logic hit(input reg_req_type r, input logic [10:0] ofs);
      hit = (r.addr == ofs);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   logic [2:0] mode_q, mode_d;
   logic [5:0] dcr_q, dcr_d;
   logic dir;
   logic ecp_mode;
   logic engine_on;
   logic queue_mode;
   logic link_rev;
   logic [CW-1:0] count_q, count_d;
   logic full;
   logic empty;

   assign dir = dcr_q[DCR_DIR];
   assign ecp_mode = (mode_q == MODE_ECP);
   assign engine_on = ecp_mode || (mode_q == MODE_COMPAT_BYTE_QUEUE);
   assign queue_mode = engine_on || (mode_q == MODE_TEST);
   // compatibility queue mode is forward only whatever the direction bit says
   assign link_rev = ecp_mode && dir;
   assign full = (count_q == DEPTH_C);
   assign empty = (count_q == '0);

   ////////////////////////////////////////////////////////////////////////////
   // host register group
   logic [7:0] data_q, data_d;
   logic errn_q, errn_d;
   logic dma_en_q, dma_en_d;
   logic service_q, service_d;
   logic host_push;
   logic host_push_tag;
   logic host_pop;
   logic service_hit;

   // queue access from register writes/reads and from DMA acknowledges
   always_comb begin
      host_push = 1'b0;
      host_push_tag = 1'b0;
      host_pop = 1'b0;
      if (reg_req.wr && hit(reg_req, OFS_DATA) && ecp_mode && !dir) begin
         host_push = 1'b1;
         host_push_tag = 1'b1; // address/run-length entry
      end
      if (queue_mode && ((reg_req.wr && hit(reg_req, OFS_FIFO)) || (dma_ack && !link_rev))) begin
         host_push = 1'b1;
      end
      if (((ecp_mode && dir) || mode_q == MODE_TEST) && reg_req.rd && hit(reg_req, OFS_FIFO)) begin
         host_pop = 1'b1;
      end
      if (dma_ack && link_rev) begin
         host_pop = 1'b1; // reverse DMA drains the queue
      end
   end

   // service request: hardware threshold sets, software clears; set wins
   assign service_hit = queue_mode && !dma_en_q &&
      (link_rev ? (count_q >= DEPTH_C - SERVICE_THRESH) : (count_q <= SERVICE_THRESH));

   always_comb begin
      data_d = data_q;
      dcr_d = dcr_q;
      mode_d = mode_q;
      errn_d = errn_q;
      dma_en_d = dma_en_q;
      service_d = service_q;
      if (reg_req.wr) begin
         if (hit(reg_req, OFS_DATA) && !engine_on) begin
            data_d = reg_req.wdata; // legacy data latch
         end
         if (hit(reg_req, OFS_DCR)) begin
            dcr_d = reg_req.wdata[5:0]; // available in every mode
         end
         if (hit(reg_req, OFS_ECR)) begin
            mode_d = reg_req.wdata[ECR_MODE +: 3];
            errn_d = reg_req.wdata[ECR_ERRN];
            dma_en_d = reg_req.wdata[ECR_DMA_TRANSFER_ENABLE];
            service_d = reg_req.wdata[ECR_SERVICE];
         end
      end
      if (service_hit) begin
         service_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_q <= DATA_RESET;
         dcr_q <= DCR_RESET;
         mode_q <= MODE_RESET;
         errn_q <= ERRN_RESET;
         dma_en_q <= DMA_TRANSFER_ENABLE_RESET;
         service_q <= SERVICE_RESET;
      end else begin
         data_q <= data_d;
         dcr_q <= dcr_d;
         mode_q <= mode_d;
         errn_q <= errn_d;
         dma_en_q <= dma_en_d;
         service_q <= service_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shared queue pointers
   logic [AW-1:0] wr_ptr_q, wr_ptr_d;
   logic [AW-1:0] rd_ptr_q, rd_ptr_d;
   logic eng_push;
   logic eng_pop;
   logic push;
   logic pop;
   logic ram_we;
   logic ram_re;
   logic [AW-1:0] ram_raddr;
   logic [ENTRY_W-1:0] ram_wdata;
   logic [ENTRY_W-1:0] ram_q;
   logic [PWORD_W-1:0] rx_byte_q, rx_byte_d;

   assign push = (host_push && !full) || eng_push;
   assign pop = (host_pop && !empty) || eng_pop;
   assign ram_we = push;
   // a test-queue read on empty re-reads the last byte; the pointer stays put
   assign ram_re = host_pop || eng_pop;
   assign ram_raddr = (host_pop && empty) ? rd_ptr_q - AW'(1) : rd_ptr_q;
   assign ram_wdata = eng_push ? {1'b0, rx_byte_q} : {host_push_tag, reg_req.wdata};

   always_comb begin
      wr_ptr_d = wr_ptr_q;
      rd_ptr_d = rd_ptr_q;
      count_d = count_q;
      if (push) begin
         wr_ptr_d = wr_ptr_q + AW'(1);
      end
      if (pop) begin
         rd_ptr_d = rd_ptr_q + AW'(1);
      end
      if (push && !pop) begin
         count_d = count_q + CW'(1);
      end else if (pop && !push) begin
         count_d = count_q - CW'(1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         wr_ptr_q <= wr_ptr_d;
         rd_ptr_q <= rd_ptr_d;
         count_q <= count_d;
      end
   end

   // one storage serves compatibility, ECP address/data and test queues
   fifo_store #(
      .WIDTH(ENTRY_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_store (
      .clk(clk),
      .we(ram_we),
      .waddr(wr_ptr_q),
      .wdata(ram_wdata),
      .re(ram_re),
      .raddr(ram_raddr),
      .rdata(ram_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link engine
   link_state_type st_q, st_d;
   logic [PWORD_W-1:0] out_byte_q, out_byte_d;
   logic strobe_q, strobe_d;
   logic host_flow_line_q, host_flow_line_d;
   logic revreq_q, revreq_d;
   logic bus_rev_q, bus_rev_d;
   logic rx_tag_q, rx_tag_d;
   logic [6:0] rle_q, rle_d;
   logic rle_pend_q, rle_pend_d;
   logic [7:0] rep_q, rep_d;
   logic busy;

   assign busy = link_in.peripheral_handshake_in;

   // the peer request line is never looked at here: direction stays software's
   always_comb begin
      st_d = st_q;
      out_byte_d = out_byte_q;
      strobe_d = strobe_q;
      host_flow_line_d = host_flow_line_q;
      revreq_d = revreq_q;
      bus_rev_d = bus_rev_q;
      rx_byte_d = rx_byte_q;
      rx_tag_d = rx_tag_q;
      rle_d = rle_q;
      rle_pend_d = rle_pend_q;
      rep_d = rep_q;
      eng_push = 1'b0;
      eng_pop = 1'b0;
      unique case (st_q)
         ST_IDLE: begin
            if (link_rev && !revreq_q) begin
               revreq_d = 1'b1; // request line goes low
               st_d = ST_TURN_REV;
            end else if (revreq_q && !link_rev) begin
               revreq_d = 1'b0; // request line back high
               host_flow_line_d = 1'b1;
               st_d = ST_TURN_FWD;
            end else if (revreq_q) begin
               if (!full) begin
                  host_flow_line_d = 1'b0; // ask the peripheral for a byte
                  st_d = ST_REV_REQ;
               end
            end else if (engine_on && !empty && !busy) begin
               eng_pop = 1'b1;
               st_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            out_byte_d = ram_q[PWORD_W-1:0];
            if (ecp_mode) begin
               host_flow_line_d = !ram_q[PWORD_W]; // low marks address/command
            end
            st_d = ST_SETUP;
         end
         ST_SETUP: begin
            strobe_d = 1'b1; // byte already stable on the lines
            st_d = ST_STROBE;
         end
         ST_STROBE: begin
            if (busy) begin
               strobe_d = 1'b0; // peripheral took the byte
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!busy) begin
               st_d = ST_IDLE; // ack released, next byte allowed
            end
         end
         ST_TURN_REV: begin
            if (!link_in.direction_turn_grant) begin
               bus_rev_d = 1'b1; // release data lines only after grant
               st_d = ST_IDLE;
            end
         end
         ST_TURN_FWD: begin
            if (link_in.direction_turn_grant) begin
               bus_rev_d = 1'b0; // drive again only after grant
               st_d = ST_IDLE;
            end
         end
         ST_REV_REQ: begin
            if (!link_in.peripheral_read_clock) begin
               rx_byte_d = pd_in; // valid while clock low
               rx_tag_d = busy; // high is data, low is command
               host_flow_line_d = 1'b1;
               st_d = ST_REV_RELEASE;
            end else if (!link_rev) begin
               host_flow_line_d = 1'b1; // withdraw the request so the turn can start
               st_d = ST_IDLE;
            end
         end
         ST_REV_RELEASE: begin
            if (link_in.peripheral_read_clock) begin
               if (!rx_tag_q) begin
                  if (!rx_byte_q[7]) begin
                     rle_d = rx_byte_q[6:0]; // run-length consumed
                     rle_pend_d = 1'b1;
                  end
                  st_d = ST_IDLE; // channel addresses are dropped
               end else begin
                  rep_d = rle_pend_q ? {1'b0, rle_q} + 8'h01 : 8'h01;
                  rle_pend_d = 1'b0;
                  st_d = ST_REPEAT;
               end
            end
         end
         ST_REPEAT: begin
            if (!full) begin
               eng_push = 1'b1; // repeat stalls on a full queue
               rep_d = rep_q - 8'h01;
               if (rep_q == 8'h01) begin
                  st_d = ST_IDLE;
               end
            end
         end
      endcase
      // leaving a queue mode abandons any half-done forward byte
      if (!engine_on && !revreq_q && st_q != ST_TURN_FWD) begin
         st_d = ST_IDLE;
         strobe_d = 1'b0;
         host_flow_line_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_q <= ST_IDLE;
         out_byte_q <= '0;
         strobe_q <= 1'b0;
         host_flow_line_q <= 1'b1;
         revreq_q <= 1'b0;
         bus_rev_q <= 1'b0;
         rx_byte_q <= '0;
         rx_tag_q <= 1'b0;
         rle_q <= '0;
         rle_pend_q <= 1'b0;
         rep_q <= '0;
      end else begin
         st_q <= st_d;
         out_byte_q <= out_byte_d;
         strobe_q <= strobe_d;
         host_flow_line_q <= host_flow_line_d;
         revreq_q <= revreq_d;
         bus_rev_q <= bus_rev_d;
         rx_byte_q <= rx_byte_d;
         rx_tag_q <= rx_tag_d;
         rle_q <= rle_d;
         rle_pend_q <= rle_pend_d;
         rep_q <= rep_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins: engine drives all but select-in (held high) in ECP mode and only strobe and data in compatibility queue mode; control register otherwise
   always_comb begin
      link_out.host_write_clock = engine_on ? !strobe_q : !dcr_q[DCR_STROBE];
      link_out.host_flow_line = ecp_mode ? host_flow_line_q : !dcr_q[DCR_AUTOFD];
      link_out.direction_select_out = ecp_mode ? !revreq_q : dcr_q[DCR_INIT];
      link_out.printer_choose_out = ecp_mode ? 1'b1 : !dcr_q[DCR_SELIN];
      pd_out = engine_on ? out_byte_q : data_q;
      if (ecp_mode) begin
         pd_oe = !bus_rev_q; // peripheral may drive only once released
      end else if (mode_q == MODE_SPP || mode_q == MODE_COMPAT_BYTE_QUEUE) begin
         pd_oe = 1'b1; // these modes are output only
      end else begin
         pd_oe = !dir;
      end
   end

   // fault is an error only while the link runs forward
   assign fault_irq = !errn_q && !link_in.peripheral_fault_request && !bus_rev_q && !revreq_q;
   assign fifo_service_request = service_q;
   assign dma_req = dma_en_q && queue_mode && (link_rev ? !empty : !full);

   ////////////////////////////////////////////////////////////////////////////
   // read data: register mux captured one cycle after the read
   logic [7:0] rdata_q, rdata_d;
   logic from_ram_q, from_ram_d;

   always_comb begin
      rdata_d = rdata_q;
      from_ram_d = 1'b0;
      if (reg_req.rd) begin
         rdata_d = 8'h00;
         if (hit(reg_req, OFS_DATA)) begin
            rdata_d = (!pd_oe) ? pd_in : data_q;
         end else if (hit(reg_req, OFS_DSR)) begin
            rdata_d = {!busy, link_in.peripheral_read_clock, link_in.direction_turn_grant,
                       link_in.online_in, link_in.peripheral_fault_request, 3'h0};
         end else if (hit(reg_req, OFS_DCR)) begin
            rdata_d = {2'h0, dcr_q};
         end else if (hit(reg_req, OFS_FIFO)) begin
            rdata_d = (mode_q == MODE_CNFG) ? CFGA_VALUE : 8'h00;
            from_ram_d = host_pop;
         end else if (hit(reg_req, OFS_CFGB)) begin
            // compression not built, so bit 7 is zero
            rdata_d = {1'b0, fault_irq, cfg_irq_sel, cfg_dma_sel[2:0]};
         end else if (hit(reg_req, OFS_ECR)) begin
            rdata_d = {mode_q, errn_q, dma_en_q, service_q, full, empty};
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
         from_ram_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         from_ram_q <= from_ram_d;
      end
   end

   assign reg_rdata = from_ram_q ? ram_q[PWORD_W-1:0] : rdata_q;
endmodule : ecp_parallel_port

/* File: tb/ecp_chk.sv */
// assertion checker for the link pins and register answers of the port
`timescale 1ns/100ps
module ecp_chk
   import ecp_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire reg_req_type reg_req,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] cfg_irq_sel,
   input wire logic [2:0] cfg_dma_sel,
   input wire link_in_type link_in,
   input wire link_out_type link_out,
   input wire logic [PWORD_W-1:0] pd_out,
   input wire logic pd_oe,
   input wire logic fault_irq
);
   logic [2:0] mode_q, mode_d;
   logic ecp_q, ecp_d;
   logic ecp, ftx;
   //////////////////////////////
   // mode shadow; ecp waits a settled cycle
   always_comb begin
      mode_d = mode_q;
      if (reg_req.wr && reg_req.addr == OFS_ECR) begin
         mode_d = reg_req.wdata[7:5];
      end
      ecp_d = (mode_q == MODE_ECP);
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_q <= MODE_RESET;
         ecp_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         ecp_q <= ecp_d;
      end
   end
   assign ecp = ecp_q && mode_q == MODE_ECP;
   assign ftx = ecp || mode_q == MODE_COMPAT_BYTE_QUEUE;
   //////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   a_select_in_off: assert property (ecp |-> link_out.printer_choose_out)
      else $error("select-in asserted");
   a_strobe_with_data: assert property (ftx && $fell(link_out.host_write_clock) |->
      pd_oe && $stable(pd_out)) else $error("unstable byte");
   a_strobe_waits_busy: assert property (ftx && !link_out.host_write_clock
      && !link_in.peripheral_handshake_in |=> !link_out.host_write_clock)
      else $error("early strobe end");
   a_strobe_ends: assert property (ftx && !link_out.host_write_clock
      && link_in.peripheral_handshake_in |-> ##1 link_out.host_write_clock)
      else $error("strobe held");
   a_release_on_grant: assert property (ecp && $fell(pd_oe) |->
      !link_out.direction_select_out && $past(!link_in.direction_turn_grant))
      else $error("release without grant");
   a_drive_on_grant: assert property (ecp && $rose(pd_oe) |->
      $past(link_in.direction_turn_grant)) else $error("drive during grant");
   a_ack_after_clock: assert property (ecp && !pd_oe && !link_out.host_flow_line
      && !link_in.peripheral_read_clock |-> ##[1:2] link_out.host_flow_line)
      else $error("host ack stuck low");
   a_fault_cause: assert property (fault_irq |-> !link_in.peripheral_fault_request
      || $past(!link_in.peripheral_fault_request)) else $error("irq without fault");
   a_fault_forward: assert property (fault_irq && ecp |-> link_out.direction_select_out
      || $past(link_out.direction_select_out)) else $error("irq in reverse");
   a_cfgb_mirror: assert property (reg_req.rd && reg_req.addr == OFS_CFGB
      && mode_q == MODE_CNFG |=> reg_rdata[5:0] == {$past(cfg_irq_sel), $past(cfg_dma_sel)})
      else $error("config b mismatch");
   c_fwd: cover property (ecp && $fell(link_out.host_write_clock));
   c_rev: cover property (ecp && !pd_oe && !link_in.peripheral_read_clock);
   c_cfgb: cover property (reg_req.rd && reg_req.addr == OFS_CFGB && mode_q == MODE_CNFG);
endmodule : ecp_chk
bind ecp_parallel_port ecp_chk chk (.clk, .nrst, .reg_req, .reg_rdata, .cfg_irq_sel,
   .cfg_dma_sel, .link_in, .link_out, .pd_out, .pd_oe, .fault_irq);

/* File: tb/ecp_peer_model.sv */
// behavioural peripheral on the far side of the parallel link
`timescale 1ns/100ps
module ecp_peer_model
   import ecp_pkg::*;
(
   input wire logic clk,
   input wire logic ecp,
   input wire logic slow,
   input wire logic fault_n,
   input wire link_out_type link_out,
   input wire logic [PWORD_W-1:0] pd_out,
   input wire logic pd_oe,
   output link_in_type link_in,
   output logic [PWORD_W-1:0] pd_in
);
   logic [8:0] got_q[$];
   logic [8:0] send_q[$];
   logic [8:0] cur;
   int st = 0;
   int hold = 0;
   initial link_in = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   initial pd_in = 8'h00;
   // one transfer at a time; hold stretches recovery so the port must wait
   always @(posedge clk) begin
      link_in.direction_turn_grant <= !(ecp && !link_out.direction_select_out);
      link_in.peripheral_fault_request <= fault_n;
      if (hold != 0) begin
         hold <= hold - 1;
      end else begin
         case (st)
            0: if (!link_out.host_write_clock && link_in.direction_turn_grant) begin
               got_q.push_back({link_out.host_flow_line, pd_out});
               link_in.peripheral_handshake_in <= 1'b1;
               st <= 1;
            end else if (ecp && !link_in.direction_turn_grant && !pd_oe
                  && !link_out.host_flow_line && link_out.printer_choose_out
                  && send_q.size() != 0) begin
               cur = send_q.pop_front();
               pd_in <= cur[7:0];
               link_in.peripheral_handshake_in <= cur[8];
               link_in.peripheral_read_clock <= 1'b0;
               st <= 2;
            end
            1: if (link_out.host_write_clock) begin
               hold <= slow ? 4 : 0;
               st <= 3;
            end
            2: if (link_out.host_flow_line) begin
               link_in.peripheral_read_clock <= 1'b1;
               hold <= slow ? 3 : 0;
               st <= 4;
            end
            3: begin
               link_in.peripheral_handshake_in <= 1'b0;
               st <= 0;
            end
            default: begin
               pd_in <= ~pd_in; // released lines must not keep the old byte
               st <= 0;
            end
         endcase
      end
   end
endmodule : ecp_peer_model

/* File: tb/ecp_parallel_port_test.sv */
// self-checking bench for the parallel port block
`timescale 1ns/100ps
module ecp_parallel_port_test import ecp_pkg::*;;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   reg_req_type reg_req = '0;
   logic [7:0] reg_rdata, pd_in, pd_out;
   logic [2:0] cfg_irq_sel = 3'h0;
   logic [2:0] cfg_dma_sel = 3'h0;
   link_in_type link_in;
   link_out_type link_out;
   logic dma_req, pd_oe, fault_irq, fifo_service_request;
   logic ecp = 1'b0, slow = 1'b0, fault_n = 1'b1;
   int failures = 0, comparisons = 0, cycles = 0, i;
   ecp_parallel_port DUT (.clk, .nrst, .reg_req, .reg_rdata, .dma_req, .dma_ack(1'b0),
      .cfg_irq_sel, .cfg_dma_sel, .link_in, .link_out, .pd_in, .pd_out, .pd_oe, .fault_irq,
      .fifo_service_request);
   ecp_peer_model peer (.clk, .ecp, .slow, .fault_n, .link_out, .pd_out, .pd_oe, .link_in,
      .pd_in);
   always #50 clk = ~clk;
   //////////////////////////////
   task automatic end_of_test;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // bus cycles run falling edge to falling edge
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_req = '{1'b0, 1'b1, a, d};
      @(negedge clk);
      reg_req = '0;
   endtask : wr
   task automatic rd(input logic [10:0] a, input logic [7:0] m, input logic [7:0] e,
         input string nm);
      @(negedge clk);
      reg_req = '{1'b1, 1'b0, a, 8'h00};
      @(negedge clk);
      reg_req = '0;
      chk(nm, {1'b0, e & m}, {1'b0, reg_rdata & m});
   endtask : rd
   task automatic wait_got(input int n);
      for (int k = 0; k < 400 && peer.got_q.size() < n; k++) @(negedge clk);
   endtask : wait_got
   //////////////////////////////
   task automatic t_legacy;
      rd(OFS_ECR, 8'hff, 8'h11, "ecr");
      rd(OFS_DCR, 8'hff, 8'h00, "dcr");
      rd(OFS_DSR, 8'hff, 8'hf8, "dsr");
      wr(OFS_DATA, 8'h5a);
      chk("pd_out", 9'h05a, {1'b0, pd_out});
      wr(OFS_DCR, 8'h05);
      chk("strobe pin", 9'h000, {8'h00, link_out.host_write_clock});
      wr(OFS_DCR, 8'h04);
      chk("init pin", 9'h001, {8'h00, link_out.direction_select_out});
      $display("test legacy done");
   endtask : t_legacy
   task automatic t_config;
      cfg_irq_sel = 3'h5;
      cfg_dma_sel = 3'h3;
      wr(OFS_ECR, 8'hf0);
      rd(OFS_FIFO, 8'hff, CFGA_VALUE, "fixed_capability_word");
      rd(OFS_CFGB, 8'h3f, 8'h2b, "irq_dma_mirror");
      cfg_irq_sel = 3'h2;
      cfg_dma_sel = 3'h1;
      rd(OFS_CFGB, 8'hbf, 8'h11, "irq_dma_mirror");
      rd(11'h005, 8'hff, 8'h00, "unmapped");
      rd(OFS_DCR, 8'hff, 8'h04, "dcr");
      $display("test config done");
   endtask : t_config
   task automatic t_test_fifo;
      wr(OFS_ECR, 8'hd0);
      for (i = 0; i < 17; i++) wr(OFS_FIFO, 8'h30 + i[7:0]);
      rd(OFS_ECR, 8'h03, 8'h02, "full");
      for (i = 0; i < 16; i++) rd(OFS_FIFO, 8'hff, 8'h30 + i[7:0], "queue");
      rd(OFS_FIFO, 8'hff, 8'h3f, "reread");
      rd(OFS_ECR, 8'h03, 8'h01, "empty");
      $display("test queue done");
   endtask : t_test_fifo
   task automatic t_compat;
      peer.got_q.delete();
      slow = 1'b1;
      wr(OFS_ECR, 8'h50);
      for (i = 0; i < 3; i++) wr(OFS_FIFO, 8'ha1 + i[7:0]);
      wait_got(3);
      for (i = 0; i < 3; i++) chk("compat byte", 9'h0a1 + i, {1'b0, peer.got_q[i][7:0]});
      slow = 1'b0;
      $display("test compat done");
   endtask : t_compat
   task automatic t_ecp_fwd;
      peer.got_q.delete();
      ecp = 1'b1;
      wr(OFS_ECR, 8'h70);
      chk("select-in", 9'h001, {8'h00, link_out.printer_choose_out});
      wr(OFS_DATA, 8'h12);
      wr(OFS_FIFO, 8'h34);
      wait_got(2);
      chk("address byte", 9'h012, peer.got_q[0]);
      chk("data byte", 9'h134, peer.got_q[1]);
      fault_n = 1'b0;
      repeat (3) @(negedge clk);
      chk("masked fault", 9'h000, {8'h00, fault_irq});
      wr(OFS_ECR, 8'h60);
      repeat (2) @(negedge clk);
      chk("fault irq", 9'h001, {8'h00, fault_irq});
      fault_n = 1'b1;
      repeat (3) @(negedge clk);
      chk("fault cleared", 9'h000, {8'h00, fault_irq});
      $display("test forward done");
   endtask : t_ecp_fwd
   task automatic t_ecp_rev;
      peer.send_q = '{9'h002, 9'h177, 9'h155, 9'h081};
      fault_n = 1'b0; // only a hint; the port keeps the direction
      wr(OFS_DCR, 8'h24);
      for (i = 0; i < 400 && peer.send_q.size() != 0; i++) @(negedge clk);
      repeat (12) @(negedge clk);
      chk("turn request", 9'h000, {8'h00, link_out.direction_select_out});
      chk("bus released", 9'h000, {8'h00, pd_oe});
      chk("hint ignored", 9'h000, {8'h00, fault_irq});
      for (i = 0; i < 3; i++) rd(OFS_FIFO, 8'hff, 8'h77, "run byte");
      rd(OFS_FIFO, 8'hff, 8'h55, "plain byte");
      rd(OFS_ECR, 8'h03, 8'h01, "drained");
      fault_n = 1'b1;
      wr(OFS_DCR, 8'h04);
      repeat (6) @(negedge clk);
      chk("forward request", 9'h001, {8'h00, link_out.direction_select_out});
      chk("bus driven", 9'h001, {8'h00, pd_oe});
      $display("test reverse done");
   endtask : t_ecp_rev
   //////////////////////////////
   // a hang counts as a mismatch; the run needs about 230 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      t_legacy();
      t_config();
      t_test_fifo();
      t_compat();
      t_ecp_fwd();
      t_ecp_rev();
      end_of_test();
   end
endmodule : ecp_parallel_port_test
